//--- logic/pfio_params.svh
// Constants for the pulse frequency input and output block
`ifndef PFIO_PARAMS_SVH
`define PFIO_PARAMS_SVH
// ============================================================
// Clock and detection timing
`define PFIO_CLK_PERIOD_NS 32'h00000028
`define PFIO_CLK_PER_MS    (32'h000F4240 / `PFIO_CLK_PERIOD_NS)
`define PFIO_PERIOD_MIN    5'h01
`define PFIO_PERIOD_MAX    5'h14
`define PFIO_PERIOD_DEF    5'h0A
// ============================================================
// Frequencies, in units of 10 Hz
`define PFIO_FREQ_CAP      14'h2710
`define PFIO_FIN_FMAX_MIN  14'h0001
`define PFIO_FIN_FMIN_DEF  14'h0000
`define PFIO_FIN_FMAX_DEF  14'h03E8
`define PFIO_FOUT_FLOOR    14'h0019
`define PFIO_FOUT_FMIN_DEF 14'h0019
`define PFIO_FOUT_FMAX_DEF 14'h03E8
`define PFIO_FREQ_SCALE    32'h00000064
`define PFIO_GEN_NUM       32'h002625A0
// ============================================================
// Encoder and wheel geometry
`define PFIO_PPR_MAX       13'h1000
`define PFIO_PPR_DEF       13'h0400
`define PFIO_RATIO_MIN     14'h000A
`define PFIO_RATIO_MAX     14'h2710
`define PFIO_RATIO_DEF     14'h03E8
`define PFIO_RATIO_ONE     64'h00000000000003E8
`define PFIO_DIAM_MIN      15'h0001
`define PFIO_DIAM_MAX      15'h4E20
`define PFIO_DIAM_DEF      15'h03E8
`define PFIO_PI_NUM        64'h0000000000000C91
`define PFIO_PI_DEN        64'h0000000000000400
// ============================================================
// Length and speed limits
`define PFIO_LEN_MIN       16'h000A
`define PFIO_LEN_MAX       16'hC350
`define PFIO_LEN_DEF       16'hC350
`define PFIO_SPD_MIN       16'h0001
`define PFIO_SPD_MAX       16'hC350
`define PFIO_SPD_DEF       16'h03E8
`define PFIO_DMM_PER_M     32'h00002710
`define PFIO_DMM_MS_TO_CMS 64'h000000000000000A
// ============================================================
// Function codes and output mapping
`define PFIO_FN_FIN_A      7'h61
`define PFIO_FN_FIN_B      7'h62
`define PFIO_FN_FOUT       7'h3F
`define PFIO_MAP_COUNT     46
`define PFIO_MAP_SEL_MAX   6'h2D
`define PFIO_MAP_SEL_DEF   6'h00
`define PFIO_PCT_FULL      10'h3E8
`endif

//--- logic/pfio_pkg.sv
// Types shared by the pulse frequency block
package pfio_pkg;
  typedef enum logic [1:0] {
    PFIO_OUT_FREQ     = 2'h0,
    PFIO_OUT_FREQ_ALT = 2'h1,
    PFIO_OUT_PWM      = 2'h2
  } pfio_out_type_t;
  typedef enum logic [1:0] {
    PFIO_MEAS_OFF   = 2'h0,
    PFIO_MEAS_COUNT = 2'h1,
    PFIO_MEAS_CALC  = 2'h3
  } pfio_meas_t;
endpackage

//--- logic/pfio_pulse_gen.sv
// Period and high-time driven pulse generator
`include "pfio_params.svh"
module pfio_pulse_gen import pfio_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Shape request
  input  wire logic        run,
  input  wire logic [16:0] period_cyc,
  input  wire logic [16:0] high_cyc,
  // Waveform
  output logic             wave
);
  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic [16:0] per_reg;
  logic [16:0] hi_reg;
  logic        wave_reg;
  logic        wave_next;
  logic        wrap;
  // ============================================================
  // New shape only taken at a period boundary, so no runt pulses
  assign wrap      = !run || (cnt_reg + 17'h00001 >= per_reg);
  assign cnt_next  = wrap ? 17'h00000 : cnt_reg + 17'h00001;
  assign wave_next = run && (cnt_next < (wrap ? high_cyc : hi_reg));
  assign wave      = wave_reg;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_reg  <= 17'h00000;
      per_reg  <= 17'h00000;
      hi_reg   <= 17'h00000;
      wave_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      wave_reg <= wave_next;
      if (wrap) begin
        per_reg <= period_cyc;
        hi_reg  <= high_cyc;
      end
    end
  end
  // ============================================================
  // Checks
  a_gen_count_bound: assert property (@(posedge core_clk) disable iff (reset)
    run && per_reg != 17'h00000 |-> cnt_reg < per_reg)
    else $error("generator counter passed its period");
  a_gen_idle_low: assert property (@(posedge core_clk) disable iff (reset)
    !run |=> !wave)
    else $error("generator drives while stopped");
endmodule

//--- logic/pfio_top.sv
// Pulse frequency input measurement and pulse output generation
// ============================================================
// What this block does
// - Input frequency is bounded by settable minimum and maximum, up to 100 kHz.
// - Input frequency is measured over a detection period of 1 to 20 ms.
// - Input pin counts as frequency input only for function codes 97 or 98.
// - Pulses per encoder revolution, 1 to 4096, scale length and speed.
// - Revolutions scale by transmission ratio 0.010 to 10.000.
// - Driving wheel diameter 0.1 to 2000.0 mm sets distance per revolution.
// - Length and speed clamp at their maxima and flag reaching them.
// - Current length and speed are read-only latest results.
// - Output type code picks frequency or PWM waveform.
// - PWM runs at the configured maximum output frequency.
// - Output pin pulses only under function code 63, between min and max.
// - A selector 0 to 45 picks the quantity driving the output.
// - Lower and upper percent limits map onto min and max; lower never above upper.
`include "pfio_params.svh"
module pfio_top import pfio_pkg::*; #(
  parameter int unsigned CYC_PER_MS = `PFIO_CLK_PER_MS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Pulse input pin and its settings
  input  wire logic        pulse_input_terminal,
  input  wire logic [6:0]  input_function_select,
  input  wire logic [13:0] fin_min_freq,
  input  wire logic [13:0] fin_max_freq,
  input  wire logic [4:0]  detect_period_ms,
  input  wire logic [12:0] pulses_per_rev,
  input  wire logic [13:0] trans_ratio,
  input  wire logic [14:0] wheel_diameter,
  input  wire logic [15:0] length_max_m,
  input  wire logic [15:0] speed_max,
  // Measurement results
  output logic [13:0]      fin_freq,
  output logic [15:0]      length_now_m,
  output logic [15:0]      speed_now,
  output logic             length_at_max,
  output logic             speed_at_max,
  // Pulse output settings
  input  wire logic [6:0]  output_function_select,
  input  wire logic [1:0]  out_pulse_type,
  input  wire logic [13:0] fout_min_freq,
  input  wire logic [13:0] max_output_frequency_setting,
  input  wire logic [5:0]  output_mapping_selector,
  input  wire logic [9:0]  map_lower_pct,
  input  wire logic [9:0]  map_upper_pct,
  input  wire logic [9:0]  monitor_vars [0:`PFIO_MAP_COUNT-1],
  // Pulse output pin
  output logic [13:0]      fout_freq,
  output logic             pulse_output_terminal
);
  // ============================================================
  // Pin synchroniser; only stage two reads stage one
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic edge_seen;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= pulse_input_terminal;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  assign edge_seen = sync2_reg && !sync3_reg;
  // ============================================================
  // Settings outside their ranges fall back to defaults
  logic        fin_en;
  logic [4:0]  period_eff;
  logic [12:0] ppr_eff;
  logic [13:0] ratio_eff;
  logic [14:0] diam_eff;
  logic [15:0] len_max_eff;
  logic [15:0] spd_max_eff;
  logic [13:0] fin_min_eff;
  logic [13:0] fin_max_eff;
  assign fin_en = input_function_select == `PFIO_FN_FIN_A ||
                  input_function_select == `PFIO_FN_FIN_B;
  assign period_eff = (detect_period_ms < `PFIO_PERIOD_MIN || detect_period_ms > `PFIO_PERIOD_MAX)
                    ? `PFIO_PERIOD_DEF : detect_period_ms;
  assign ppr_eff = (pulses_per_rev == 13'h0000 || pulses_per_rev > `PFIO_PPR_MAX)
                 ? `PFIO_PPR_DEF : pulses_per_rev;
  assign ratio_eff = (trans_ratio < `PFIO_RATIO_MIN || trans_ratio > `PFIO_RATIO_MAX)
                   ? `PFIO_RATIO_DEF : trans_ratio;
  assign diam_eff = (wheel_diameter < `PFIO_DIAM_MIN || wheel_diameter > `PFIO_DIAM_MAX)
                  ? `PFIO_DIAM_DEF : wheel_diameter;
  assign len_max_eff = (length_max_m < `PFIO_LEN_MIN || length_max_m > `PFIO_LEN_MAX)
                     ? `PFIO_LEN_DEF : length_max_m;
  assign spd_max_eff = (speed_max < `PFIO_SPD_MIN || speed_max > `PFIO_SPD_MAX)
                     ? `PFIO_SPD_DEF : speed_max;
  assign fin_max_eff = (fin_max_freq < `PFIO_FIN_FMAX_MIN || fin_max_freq > `PFIO_FREQ_CAP)
                     ? `PFIO_FIN_FMAX_DEF : fin_max_freq;
  assign fin_min_eff = (fin_min_freq > fin_max_eff) ? `PFIO_FIN_FMIN_DEF : fin_min_freq;
  // ============================================================
  // Detection window state machine
  pfio_meas_t  state_reg;
  pfio_meas_t  state_next;
  logic [19:0] win_cnt_reg;
  logic [19:0] win_limit;
  logic [17:0] edge_cnt_reg;
  logic [17:0] cnt_lat_reg;
  logic        win_end;
  logic        counting;
  assign win_limit = 20'(32'(period_eff) * CYC_PER_MS);
  // Period may shrink mid-window; >= ends it at once instead of letting the counter wrap
  assign win_end   = state_reg == PFIO_MEAS_COUNT && win_cnt_reg >= win_limit - 20'h00001;
  assign counting  = state_reg == PFIO_MEAS_COUNT && !win_end;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PFIO_MEAS_OFF: begin
        if (fin_en) state_next = PFIO_MEAS_COUNT;
      end
      PFIO_MEAS_COUNT: begin
        if (!fin_en) state_next = PFIO_MEAS_OFF;
        else if (win_end) state_next = PFIO_MEAS_CALC;
      end
      PFIO_MEAS_CALC: begin
        state_next = fin_en ? PFIO_MEAS_COUNT : PFIO_MEAS_OFF;
      end
      default: begin
        state_next = PFIO_MEAS_OFF;
      end
    endcase
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg    <= PFIO_MEAS_OFF;
      win_cnt_reg  <= 20'h00000;
      edge_cnt_reg <= 18'h00000;
      cnt_lat_reg  <= 18'h00000;
    end else begin
      state_reg    <= state_next;
      win_cnt_reg  <= counting ? win_cnt_reg + 20'h00001 : 20'h00000;
      edge_cnt_reg <= counting ? edge_cnt_reg + 18'(edge_seen) : 18'h00000;
      if (win_end) cnt_lat_reg <= edge_cnt_reg + 18'(edge_seen);
    end
  end
  // ============================================================
  // Frequency, distance and speed from one window's count
  logic [31:0] freq_raw;
  logic [13:0] freq_meas;
  logic [63:0] dist_num;
  logic [63:0] dist_den;
  logic [31:0] dist_dmm;
  logic [31:0] len_limit;
  logic [32:0] len_sum;
  logic [31:0] len_next;
  logic [63:0] spd_raw;
  logic [31:0] acc_reg;
  logic        calc;
  assign calc      = state_reg == PFIO_MEAS_CALC;
  assign freq_raw  = (32'(cnt_lat_reg) * `PFIO_FREQ_SCALE) / 32'(period_eff);
  assign freq_meas = (freq_raw > 32'(fin_max_eff)) ? fin_max_eff
                   : (freq_raw < 32'(fin_min_eff)) ? 14'h0000 : freq_raw[13:0];
  assign dist_num  = 64'(cnt_lat_reg) * 64'(ratio_eff) * 64'(diam_eff) * `PFIO_PI_NUM;
  assign dist_den  = 64'(ppr_eff) * `PFIO_RATIO_ONE * `PFIO_PI_DEN;
  assign dist_dmm  = 32'(dist_num / dist_den);
  assign len_limit = 32'(len_max_eff) * `PFIO_DMM_PER_M;
  assign len_sum   = 33'(acc_reg) + 33'(dist_dmm);
  assign len_next  = (len_sum >= 33'(len_limit)) ? len_limit : len_sum[31:0];
  assign spd_raw   = (64'(dist_dmm) * `PFIO_DMM_MS_TO_CMS) / 64'(period_eff);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_reg       <= 32'h00000000;
      fin_freq      <= 14'h0000;
      length_now_m  <= 16'h0000;
      speed_now     <= 16'h0000;
      length_at_max <= 1'b0;
      speed_at_max  <= 1'b0;
    end else if (calc) begin
      acc_reg       <= len_next;
      fin_freq      <= freq_meas;
      length_now_m  <= 16'(len_next / `PFIO_DMM_PER_M);
      length_at_max <= len_next >= len_limit;
      speed_now     <= (spd_raw >= 64'(spd_max_eff)) ? spd_max_eff : spd_raw[15:0];
      speed_at_max  <= spd_raw >= 64'(spd_max_eff);
    end else if (state_reg == PFIO_MEAS_OFF) begin
      fin_freq      <= 14'h0000;
      speed_now     <= 16'h0000;
      speed_at_max  <= 1'b0;
    end
  end
  // ============================================================
  // Output mapping; dividers are wide but settle within a cycle at 25 MHz
  logic [5:0]  sel_eff;
  logic [9:0]  map_val;
  logic [9:0]  lo_pct;
  logic [9:0]  hi_pct;
  logic        below;
  logic        above;
  logic [13:0] fo_min;
  logic [13:0] fo_max;
  logic [31:0] frac_f;
  logic [13:0] f_sel;
  logic [31:0] duty;
  logic [31:0] per_f;
  logic [31:0] per_pwm;
  logic [31:0] hi_pwm;
  logic        is_pwm;
  logic [16:0] period_reg;
  logic [16:0] high_reg;
  logic        out_en_reg;
  assign sel_eff = (output_mapping_selector > `PFIO_MAP_SEL_MAX)
                 ? `PFIO_MAP_SEL_DEF : output_mapping_selector;
  assign map_val = (monitor_vars[sel_eff] > `PFIO_PCT_FULL) ? `PFIO_PCT_FULL
                 : monitor_vars[sel_eff];
  assign lo_pct  = (map_lower_pct > `PFIO_PCT_FULL) ? `PFIO_PCT_FULL : map_lower_pct;
  assign hi_pct  = (map_upper_pct < lo_pct) ? lo_pct
                 : (map_upper_pct > `PFIO_PCT_FULL) ? `PFIO_PCT_FULL : map_upper_pct;
  assign below   = map_val <= lo_pct;
  assign above   = map_val >= hi_pct;
  assign fo_min  = (fout_min_freq < `PFIO_FOUT_FLOOR) ? `PFIO_FOUT_FLOOR
                 : (fout_min_freq > `PFIO_FREQ_CAP) ? `PFIO_FREQ_CAP : fout_min_freq;
  assign fo_max  = (max_output_frequency_setting < fo_min) ? fo_min
                 : (max_output_frequency_setting > `PFIO_FREQ_CAP) ? `PFIO_FREQ_CAP
                 : max_output_frequency_setting;
  assign frac_f  = below ? 32'h00000000
                 : (32'(map_val - lo_pct) * 32'(fo_max - fo_min)) / 32'(hi_pct - lo_pct);
  assign f_sel   = below ? fo_min : above ? fo_max : fo_min + 14'(frac_f);
  assign duty    = below ? 32'h00000000 : above ? 32'(`PFIO_PCT_FULL)
                 : (32'(map_val - lo_pct) * 32'(`PFIO_PCT_FULL)) / 32'(hi_pct - lo_pct);
  assign is_pwm  = out_pulse_type == PFIO_OUT_PWM;
  assign per_f   = `PFIO_GEN_NUM / 32'(f_sel);
  assign per_pwm = `PFIO_GEN_NUM / 32'(fo_max);
  assign hi_pwm  = (per_pwm * duty) / 32'(`PFIO_PCT_FULL);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      period_reg <= 17'h00000;
      high_reg   <= 17'h00000;
      out_en_reg <= 1'b0;
      fout_freq  <= 14'h0000;
    end else begin
      period_reg <= is_pwm ? per_pwm[16:0] : per_f[16:0];
      high_reg   <= is_pwm ? hi_pwm[16:0] : per_f[17:1];
      out_en_reg <= output_function_select == `PFIO_FN_FOUT;
      fout_freq  <= is_pwm ? fo_max : f_sel;
    end
  end
  pfio_pulse_gen u_gen (
    .core_clk   (core_clk),
    .reset      (reset),
    .run        (out_en_reg),
    .period_cyc (period_reg),
    .high_cyc   (high_reg),
    .wave       (pulse_output_terminal)
  );
  // ============================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_window_done;
    state_reg == PFIO_MEAS_COUNT && win_end && fin_en;
  endsequence
  a_fsel_gate: assert property (!fin_en |=> state_reg == PFIO_MEAS_OFF)
    else $error("measurement runs with wrong input function");
  a_window_calc: assert property (s_window_done |=> calc ##1 !calc)
    else $error("window end not followed by one calc cycle");
  a_window_bound: assert property ($stable(win_limit) |-> win_cnt_reg < win_limit)
    else $error("window counter past detection period");
  a_freq_window: assert property (calc |=> fin_freq <= $past(fin_max_eff))
    else $error("input frequency above configured maximum");
  a_len_clamp: assert property (calc |=> acc_reg <= $past(len_limit))
    else $error("length passed its maximum");
  a_speed_flag: assert property (calc && spd_raw >= 64'(spd_max_eff)
    |=> speed_at_max && speed_now == $past(spd_max_eff))
    else $error("speed limit not flagged");
  a_out_gate: assert property (out_en_reg == 1'b0 |=> !pulse_output_terminal)
    else $error("output pin pulses without function 63");
  a_clamp_low: assert property (below |=> fout_freq == $past(fo_min) || $past(is_pwm))
    else $error("output not clamped to minimum");
  a_pwm_rate: assert property (is_pwm |=> period_reg == $past(per_pwm[16:0]))
    else $error("pwm period not from maximum frequency");
  a_fout_range: assert property (!is_pwm
    |=> fout_freq >= $past(fo_min) && fout_freq <= $past(fo_max))
    else $error("output frequency outside its mapped range");
endmodule

//--- tb/pfio_pulse_peer.sv
// Encoder pulse source and pulse reading equipment around the block
module pfio_pulse_peer (
  // Clock
  input  wire logic        core_clk,
  // Encoder side
  input  wire logic        src_en,
  input  wire logic [7:0]  src_period,
  output logic             src_pin,
  // Reader side
  input  wire logic        wave,
  output logic [16:0]      per_cyc,
  output logic [16:0]      hi_cyc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  ph;
  logic [16:0] cnt;
  logic [16:0] hcnt;
  logic        wave_d;
  initial begin
    src_pin = 1'b0;
    ph = 8'h00;
    cnt = 17'h00000;
    hcnt = 17'h00000;
    per_cyc = 17'h00000;
    hi_cyc = 17'h00000;
    wave_d = 1'b0;
  end
  // ============================================================
  // Encoder: two cycles high per period, stands low while stopped
  always @(negedge core_clk) begin
    if (src_en) begin
      ph <= (ph + 8'h01 >= src_period) ? 8'h00 : ph + 8'h01;
      src_pin <= (ph < 8'h02);
    end else begin
      ph <= 8'h00;
      src_pin <= 1'b0;
    end
  end
  // ============================================================
  // Reader: period and high time, rise to rise, in clock cycles
  always @(posedge core_clk) begin
    wave_d <= wave;
    if (wave && !wave_d) begin
      per_cyc <= cnt;
      hi_cyc <= hcnt;
      cnt <= 17'h00001;
      hcnt <= 17'h00001;
    end else begin
      cnt <= cnt + 17'h00001;
      hcnt <= hcnt + {16'h0000, wave};
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the pulse frequency input and output block
`include "pfio_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short millisecond keeps windows small; a window is period times this
  localparam int CPM = 25;
  logic core_clk, reset, src_en;
  logic [7:0] src_period;
  logic pin_in, pin_out, len_max_f, spd_max_f;
  logic [6:0] fn_in, fn_out;
  logic [13:0] fmin_in, fmax_in, ratio, fmin_out, fmax_out, fin_freq, fout_freq;
  logic [4:0] period;
  logic [12:0] ppr;
  logic [14:0] diam;
  logic [15:0] len_max, spd_max, len_now, spd_now;
  logic [1:0] otype;
  logic [5:0] sel;
  logic [9:0] lo_pct, up_pct;
  logic [9:0] mon [0:`PFIO_MAP_COUNT-1];
  logic [16:0] per_cyc, hi_cyc;
  int err_count, n_tests;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  pfio_top #(.CYC_PER_MS(CPM)) i_pfio_top (.core_clk(core_clk), .reset(reset),
    .pulse_input_terminal(pin_in), .input_function_select(fn_in),
    .fin_min_freq(fmin_in), .fin_max_freq(fmax_in), .detect_period_ms(period),
    .pulses_per_rev(ppr), .trans_ratio(ratio), .wheel_diameter(diam),
    .length_max_m(len_max), .speed_max(spd_max), .fin_freq(fin_freq),
    .length_now_m(len_now), .speed_now(spd_now), .length_at_max(len_max_f),
    .speed_at_max(spd_max_f), .output_function_select(fn_out),
    .out_pulse_type(otype), .fout_min_freq(fmin_out),
    .max_output_frequency_setting(fmax_out), .output_mapping_selector(sel),
    .map_lower_pct(lo_pct), .map_upper_pct(up_pct), .monitor_vars(mon),
    .fout_freq(fout_freq), .pulse_output_terminal(pin_out));
  pfio_pulse_peer i_pfio_pulse_peer (.core_clk(core_clk), .src_en(src_en),
    .src_period(src_period), .src_pin(pin_in), .wave(pin_out),
    .per_cyc(per_cyc), .hi_cyc(hi_cyc));
  // ============================================================
  // Reporting
  task automatic test_done();
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Whole measurement window plus its calculation cycle, twice over
  task automatic two_windows();
    cyc(2 * (period * CPM + 1) + 4);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset();
    reset = 1'b1;
    cyc(3);
    check({1'b0, fin_freq, len_now, pin_out}, 32'h00000000);
    reset = 1'b0;
  endtask
  task automatic t_codes();
    logic [6:0] codes [4];
    codes = '{7'h60, 7'h61, 7'h62, 7'h63};
    for (int i = 0; i < 4; i++) begin
      fn_in = codes[i];
      two_windows();
      check(fin_freq, (i == 1 || i == 2) ? 32'h000001F4 : 32'h00000000);
    end
  endtask
  task automatic t_period(input logic [4:0] p);
    fn_in = 7'h00;
    period = p;
    cyc(4);
    fn_in = 7'h61;
    cyc(p * CPM);
    check(fin_freq, 32'h00000000);
    cyc(4);
    check(fin_freq != 14'h0000, 32'h00000001);
    two_windows();
    check(fin_freq, 32'h000001F4);
  endtask
  task automatic t_fin_limits();
    fmax_in = 14'h012C;
    two_windows();
    check(fin_freq, 32'h0000012C);
    fmax_in = 14'h03E8;
    fmin_in = 14'h0258;
    two_windows();
    check(fin_freq, 32'h00000000);
    fmin_in = 14'h0000;
  endtask
  // Fifty pulses a window; ppr and diameter cancel the pi factor exactly
  task automatic t_speed();
    ppr = 13'h0C91;
    diam = 15'h0400;
    two_windows();
    check({spd_now, 15'h0000, spd_max_f}, 32'h00320000);
    ratio = 14'h07D0;
    two_windows();
    check(spd_now, 32'h00000064);
    spd_max = 16'h003C;
    two_windows();
    check({spd_now, 15'h0000, spd_max_f}, 32'h003C0001);
  endtask
  task automatic t_length();
    t_reset();
    ppr = 13'h0001;
    ratio = 14'h0400;
    diam = 15'h2710;
    len_max = 16'h000A;
    two_windows();
    check({len_now, 15'h0000, len_max_f}, 32'h000A0001);
  endtask
  task automatic out_case(input logic [5:0] s, input logic [9:0] m,
                          input logic [9:0] lo, input logic [9:0] up,
                          input logic [13:0] fmn, input logic [13:0] fmx,
                          input logic [13:0] exp);
    sel = s;
    mon[s] = m;
    lo_pct = lo;
    up_pct = up;
    fmin_out = fmn;
    fmax_out = fmx;
    cyc(4);
    check(fout_freq, exp);
  endtask
  task automatic t_out_map();
    fn_out = 7'h3F;
    otype = 2'h0;
    out_case(6'h00, 10'h3E8, 10'h000, 10'h3E8, 14'h0019, 14'h03E8, 14'h03E8);
    out_case(6'h05, 10'h000, 10'h000, 10'h3E8, 14'h0019, 14'h03E8, 14'h0019);
    out_case(6'h05, 10'h1F4, 10'h000, 10'h3E8, 14'h0064, 14'h044C, 14'h0258);
    out_case(6'h07, 10'h064, 10'h0C8, 10'h320, 14'h0064, 14'h044C, 14'h0064);
    out_case(6'h07, 10'h384, 10'h0C8, 10'h320, 14'h0064, 14'h044C, 14'h044C);
  endtask
  // Full-scale frequency gives a 250 cycle period
  task automatic t_out_wave();
    for (int t = 0; t < 2; t++) begin
      // Generator only reloads at a period boundary; a stop and restart loads the new shape now
      fn_out = 7'h00;
      otype = t[1:0];
      out_case(6'h00, 10'h3E8, 10'h000, 10'h3E8, 14'h0019, 14'h2710, 14'h2710);
      fn_out = 7'h3F;
      cyc(800);
      check({15'h0000, per_cyc}, 32'h000000FA);
      check({15'h0000, hi_cyc}, 32'h0000007D);
    end
    fn_out = 7'h00;
    otype = 2'h2;
    out_case(6'h00, 10'h190, 10'h000, 10'h3E8, 14'h0019, 14'h2710, 14'h2710);
    fn_out = 7'h3F;
    cyc(800);
    check({15'h0000, per_cyc}, 32'h000000FA);
    check({15'h0000, hi_cyc}, 32'h00000064);
    fn_out = 7'h00;
    cyc(4);
    for (int i = 0; i < 300; i++) begin
      @(negedge core_clk);
      if (pin_out !== 1'b0) begin
        check(pin_out, 32'h00000000);
        break;
      end
    end
  endtask
  // ============================================================
  // Main sequence and hang guard
  initial begin
    err_count = 0;
    n_tests = 0;
    reset = 1'b1;
    src_en = 1'b1;
    src_period = 8'h05;
    fn_in = 7'h00;
    fmin_in = 14'h0000;
    fmax_in = 14'h03E8;
    period = 5'h0A;
    ppr = 13'h0400;
    ratio = 14'h03E8;
    diam = 15'h03E8;
    len_max = 16'hC350;
    spd_max = 16'h03E8;
    fn_out = 7'h00;
    otype = 2'h0;
    fmin_out = 14'h0019;
    fmax_out = 14'h03E8;
    sel = 6'h00;
    lo_pct = 10'h000;
    up_pct = 10'h3E8;
    for (int i = 0; i < `PFIO_MAP_COUNT; i++) mon[i] = 10'h000;
    t_reset();
    t_codes();
    t_period(5'h01);
    t_period(5'h14);
    period = 5'h0A;
    t_fin_limits();
    t_speed();
    t_length();
    t_out_map();
    t_out_wave();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    test_done();
  end
endmodule
